// [drs_map.svh]
// constants for the dual-rank command and address host controller
`ifndef DRS_MAP_SVH
`define DRS_MAP_SVH
`define DRS_CLK_MHZ 40
`define DRS_REF_COUNT 8192
`define DRS_REF_WIN_NORM_MS 64
`define DRS_REF_WIN_HOT_MS 32
// longest allowed spacing, so integer division rounds down
`define DRS_REFI_NORM_CYC ((`DRS_REF_WIN_NORM_MS * `DRS_CLK_MHZ * 1000) / `DRS_REF_COUNT)
`define DRS_REFI_HOT_CYC ((`DRS_REF_WIN_HOT_MS * `DRS_CLK_MHZ * 1000) / `DRS_REF_COUNT)
`define DRS_TRFC_NS 260
`define DRS_TRFC_CYC ((`DRS_TRFC_NS * `DRS_CLK_MHZ + 999) / 1000)
`define DRS_CMD_GAP_CYC 2
`define DRS_SR_EXIT_CYC 8
`define DRS_RST_HOLD_US 200
`define DRS_CKE_WAIT_US 500
`define DRS_CMD_LMR 3'h0
`define DRS_CMD_REF 3'h1
`define DRS_CMD_PRE 3'h2
`define DRS_CMD_ACT 3'h3
`define DRS_CMD_WR 3'h4
`define DRS_CMD_RD 3'h5
`define DRS_CMD_NOP 3'h7
`define DRS_AUTO_CLOSE_BIT 10
`define DRS_CHOP_BIT 12
`define DRS_MR0_SEL 3'h0
`define DRS_MR0_CHOP_OTF 15'h0001
`define DRS_MR0_LAT_LSB 4
`define DRS_RL_GRADE0 4'hd
`define DRS_RL_GRADE1 4'hb
`define DRS_RL_GRADE2 4'h9
`define DRS_RL_GRADE3 4'h7
`endif

// [drs_pkg.sv]
// types for the dual-rank command and address host controller
package drs_pkg;
	typedef enum logic [3:0] {
		S_RST_HOLD, S_CKE_WAIT, S_MODE_LOAD, S_IDLE, S_GAP, S_PD, S_SR_ENTER, S_SR, S_SR_EXIT
	} drs_state_t;
	typedef enum logic [1:0] {TRK_NONE, TRK_ACT, TRK_PRE, TRK_PREALL} drs_trk_op_t;
endpackage

// [drs_bank_track.sv]
// open-row table of the eight banks of one rank
module drs_bank_track (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// table update
	input drs_pkg::drs_trk_op_t trkOp,
	input wire logic [2:0] trkBank,
	input wire logic [14:0] trkRow,
	// lookup
	input wire logic [2:0] lookBank,
	output logic lookOpen,
	output logic [14:0] lookRow,
	output logic anyOpen
);
	logic [7:0] openVec;
	logic [14:0] rowVec [8];

	for (genvar b = 0; b < 8; b++) begin : gBank
		logic openQ, openD;
		logic [14:0] rowQ, rowD;
		always_comb begin
			openD = openQ;
			rowD = rowQ;
			if (trkOp == drs_pkg::TRK_PREALL) begin
				openD = 1'b0;
			end else if (trkBank == 3'(b)) begin
				if (trkOp == drs_pkg::TRK_ACT) begin
					openD = 1'b1;
					rowD = trkRow;
				end else if (trkOp == drs_pkg::TRK_PRE) begin
					openD = 1'b0;
				end
			end
		end
		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				openQ <= 1'b0;
				rowQ <= 15'h0000;
			end else begin
				openQ <= openD;
				rowQ <= rowD;
			end
		end
		assign openVec[b] = openQ;
		assign rowVec[b] = rowQ;
	end

	assign lookOpen = openVec[lookBank];
	assign lookRow = rowVec[lookBank];
	assign anyOpen = |openVec;
endmodule

// [drs_host_ctrl.sv]
// host controller driving the command, address and clock-enable pins of a two-rank memory
`include "drs_map.svh"
module drs_host_ctrl #(
	parameter int RstHoldCyc = `DRS_RST_HOLD_US * `DRS_CLK_MHZ,
	parameter int CkeWaitCyc = `DRS_CKE_WAIT_US * `DRS_CLK_MHZ
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// straps and environment
	input wire logic [1:0] speedGrade,
	input wire logic hotTemp,
	// user access
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqRank,
	input wire logic [2:0] reqBank,
	input wire logic [14:0] reqRow,
	input wire logic [9:0] reqCol,
	input wire logic reqChopFour,
	input wire logic reqAutoClose,
	output logic reqReady,
	output logic reqDone,
	// power control and status
	input wire logic pdReq,
	input wire logic srReq,
	output logic pdActive,
	output logic srActive,
	output logic initDone,
	output logic [3:0] readLatency,
	// memory pins
	output logic memResetN,
	output logic ckEnable,
	output logic [1:0] cke,
	output logic [1:0] csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [2:0] ba,
	output logic [14:0] addr,
	output logic [1:0] termEnable
);
	drs_pkg::drs_state_t state_q, state_d, ret_q, ret_d;
	logic [15:0] cnt_q, cnt_d;
	logic rank_q, rank_d, pend_q, pend_d, pendClr, accept;
	logic pendWrite_q, pendWrite_d, pendRank_q, pendRank_d;
	logic pendChop_q, pendChop_d, pendClose_q, pendClose_d;
	logic [2:0] pendBank_q, pendBank_d;
	logic [14:0] pendRow_q, pendRow_d;
	logic [9:0] pendCol_q, pendCol_d;
	logic [1:0] refPend_q, refPend_d, refClr;
	logic [8:0] refTimer_q, refTimer_d;
	logic [3:0] lat_q, lat_d;
	logic [1:0] cke_q, cke_d, csN_q, csN_d, term_q, term_d;
	logic [2:0] cmd_q, cmd_d, ba_q, ba_d;
	logic [14:0] addr_q, addr_d, modeOp;
	logic rstN_q, rstN_d, ckEn_q, ckEn_d, ready_q, ready_d, done_q, done_d;
	logic pdAct_q, pdAct_d, srAct_q, srAct_d, init_q, init_d;
	logic [1:0] lookOpen, anyOpen;
	logic [14:0] lookRow [2];
	drs_pkg::drs_trk_op_t trkOp [2];

	// each rank keeps its own bank table
	for (genvar r = 0; r < 2; r++) begin : gRank
		drs_bank_track uTrack (
			.sys_clk(sys_clk), .sys_rst(sys_rst), .trkOp(trkOp[r]), .trkBank(pendBank_q),
			.trkRow(pendRow_q), .lookBank(pendBank_q), .lookOpen(lookOpen[r]),
			.lookRow(lookRow[r]), .anyOpen(anyOpen[r])
		);
	end

	// latency field plus on-the-fly chop enable
	assign modeOp = (15'(lat_q) << `DRS_MR0_LAT_LSB) | `DRS_MR0_CHOP_OTF;

	always_comb begin
		accept = reqValid && ready_q;
		pend_d = accept || (pend_q && !pendClr);
		pendWrite_d = accept ? reqWrite : pendWrite_q;
		pendRank_d = accept ? reqRank : pendRank_q;
		pendBank_d = accept ? reqBank : pendBank_q;
		pendRow_d = accept ? reqRow : pendRow_q;
		pendCol_d = accept ? reqCol : pendCol_q;
		pendChop_d = accept ? reqChopFour : pendChop_q;
		pendClose_d = accept ? reqAutoClose : pendClose_q;
		ready_d = init_d && !pend_d;
	end

	always_comb begin
		refTimer_d = refTimer_q;
		refPend_d = refPend_q & ~refClr;
		if (init_q) begin
			if (refTimer_q == 9'h000) begin
				refTimer_d = hotTemp ? 9'(`DRS_REFI_HOT_CYC - 1) : 9'(`DRS_REFI_NORM_CYC - 1);
				// one refresh owed per rank, set wins
				refPend_d = 2'h3;
			end else begin
				refTimer_d = refTimer_q - 9'h001;
			end
		end
	end

	always_comb begin
		logic issue;
		logic r;
		logic [15:0] gap;
		issue = 1'b0;
		r = 1'b0;
		gap = 16'(`DRS_CMD_GAP_CYC);
		state_d = state_q;
		ret_d = ret_q;
		cnt_d = cnt_q;
		rank_d = rank_q;
		csN_d = 2'h3;
		cmd_d = `DRS_CMD_NOP;
		ba_d = ba_q;
		addr_d = addr_q;
		term_d = 2'h0;
		cke_d = cke_q;
		rstN_d = rstN_q;
		ckEn_d = ckEn_q;
		lat_d = lat_q;
		init_d = init_q;
		pdAct_d = pdAct_q;
		srAct_d = srAct_q;
		done_d = 1'b0;
		pendClr = 1'b0;
		refClr = 2'h0;
		trkOp[0] = drs_pkg::TRK_NONE;
		trkOp[1] = drs_pkg::TRK_NONE;
		unique case (state_q)
			drs_pkg::S_RST_HOLD: begin
				// memory reset held low with clock running
				rstN_d = 1'b0;
				ckEn_d = 1'b1;
				if (cnt_q == 16'(RstHoldCyc - 1)) begin
					rstN_d = 1'b1;
					cnt_d = 16'h0000;
					state_d = drs_pkg::S_CKE_WAIT;
					unique case (speedGrade)
						2'h0: lat_d = `DRS_RL_GRADE0;
						2'h1: lat_d = `DRS_RL_GRADE1;
						2'h2: lat_d = `DRS_RL_GRADE2;
						2'h3: lat_d = `DRS_RL_GRADE3;
					endcase
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end
			drs_pkg::S_CKE_WAIT: begin
				if (cnt_q == 16'(CkeWaitCyc - 1)) begin
					cke_d = 2'h3;
					rank_d = 1'b0;
					state_d = drs_pkg::S_MODE_LOAD;
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end
			drs_pkg::S_MODE_LOAD: begin
				// load mode_reg_zero, one rank at a time
				r = rank_q;
				cmd_d = `DRS_CMD_LMR;
				ba_d = `DRS_MR0_SEL;
				addr_d = modeOp;
				issue = 1'b1;
				ret_d = rank_q ? drs_pkg::S_IDLE : drs_pkg::S_MODE_LOAD;
				rank_d = !rank_q;
				init_d = rank_q;
			end
			drs_pkg::S_IDLE: begin
				if (refPend_q != 2'h0) begin
					r = !refPend_q[0];
					issue = 1'b1;
					ret_d = drs_pkg::S_IDLE;
					if (anyOpen[r]) begin
						cmd_d = `DRS_CMD_PRE;
						addr_d = 15'h0001 << `DRS_AUTO_CLOSE_BIT;
						trkOp[r] = drs_pkg::TRK_PREALL;
					end else begin
						cmd_d = `DRS_CMD_REF;
						refClr[r] = 1'b1;
						gap = 16'(`DRS_TRFC_CYC);
					end
				end else if (srReq) begin
					rank_d = 1'b0;
					state_d = drs_pkg::S_SR_ENTER;
				end else if (pdReq && !pend_q) begin
					// active power-down when any row open
					cke_d = 2'h0;
					pdAct_d = |anyOpen;
					state_d = drs_pkg::S_PD;
				end else if (pend_q) begin
					r = pendRank_q;
					// bank inputs name the target bank
					ba_d = pendBank_q;
					issue = 1'b1;
					ret_d = drs_pkg::S_IDLE;
					if (!lookOpen[r]) begin
						cmd_d = `DRS_CMD_ACT;
						addr_d = pendRow_q;
						trkOp[r] = drs_pkg::TRK_ACT;
					end else if (lookRow[r] != pendRow_q) begin
						cmd_d = `DRS_CMD_PRE;
						addr_d = 15'h0000;
						trkOp[r] = drs_pkg::TRK_PRE;
					end else begin
						// column access on the open row
						cmd_d = pendWrite_q ? `DRS_CMD_WR : `DRS_CMD_RD;
						addr_d = 15'(pendCol_q);
						addr_d[`DRS_AUTO_CLOSE_BIT] = pendClose_q;
						// chop select, low for four beats
						addr_d[`DRS_CHOP_BIT] = !pendChop_q;
						if (pendClose_q) begin
							trkOp[r] = drs_pkg::TRK_PRE;
						end
						term_d[r] = pendWrite_q;
						pendClr = 1'b1;
						done_d = 1'b1;
					end
				end
			end
			drs_pkg::S_GAP: begin
				if (cnt_q == 16'h0000) begin
					state_d = ret_q;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			drs_pkg::S_PD: begin
				// leave power-down early so refresh is never starved
				if (!pdReq || refPend_q != 2'h0) begin
					cke_d = 2'h3;
					pdAct_d = 1'b0;
					cnt_d = 16'(`DRS_CMD_GAP_CYC - 1);
					ret_d = drs_pkg::S_IDLE;
					state_d = drs_pkg::S_GAP;
				end
			end
			drs_pkg::S_SR_ENTER: begin
				r = rank_q;
				issue = 1'b1;
				ret_d = drs_pkg::S_SR_ENTER;
				if (anyOpen[r]) begin
					cmd_d = `DRS_CMD_PRE;
					addr_d = 15'h0001 << `DRS_AUTO_CLOSE_BIT;
					trkOp[r] = drs_pkg::TRK_PREALL;
				end else begin
					cmd_d = `DRS_CMD_REF;
					cke_d[r] = 1'b0;
					refClr[r] = 1'b1;
					rank_d = 1'b1;
					if (rank_q) begin
						ret_d = drs_pkg::S_SR;
						srAct_d = 1'b1;
					end
				end
			end
			drs_pkg::S_SR: begin
				// clock stopped while in self refresh
				ckEn_d = 1'b0;
				if (!srReq) begin
					ckEn_d = 1'b1;
					cnt_d = 16'(`DRS_SR_EXIT_CYC - 1);
					state_d = drs_pkg::S_SR_EXIT;
				end
			end
			drs_pkg::S_SR_EXIT: begin
				// clock-enable rises only after clock restarts
				if (cnt_q == 16'h0000) begin
					cke_d = 2'h3;
					srAct_d = 1'b0;
					cnt_d = 16'(`DRS_SR_EXIT_CYC - 1);
					ret_d = drs_pkg::S_IDLE;
					state_d = drs_pkg::S_GAP;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			default: state_d = drs_pkg::S_RST_HOLD;
		endcase
		if (issue) begin
			// one rank selected with the strobes
			csN_d = r ? 2'h1 : 2'h2;
			cnt_d = gap - 16'h0001;
			state_d = drs_pkg::S_GAP;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= drs_pkg::S_RST_HOLD;
			ret_q <= drs_pkg::S_IDLE;
			cnt_q <= 16'h0000;
			rank_q <= 1'b0;
			pend_q <= 1'b0;
			{pendWrite_q, pendRank_q, pendChop_q, pendClose_q} <= 4'h0;
			pendBank_q <= 3'h0;
			pendRow_q <= 15'h0000;
			pendCol_q <= 10'h000;
			refPend_q <= 2'h0;
			refTimer_q <= 9'h000;
			lat_q <= 4'h0;
			cke_q <= 2'h0;
			csN_q <= 2'h3;
			term_q <= 2'h0;
			cmd_q <= `DRS_CMD_NOP;
			ba_q <= 3'h0;
			addr_q <= 15'h0000;
			{rstN_q, ckEn_q, ready_q, done_q, pdAct_q, srAct_q, init_q} <= 7'h00;
		end else begin
			state_q <= state_d;
			ret_q <= ret_d;
			cnt_q <= cnt_d;
			rank_q <= rank_d;
			pend_q <= pend_d;
			{pendWrite_q, pendRank_q, pendChop_q, pendClose_q} <= {pendWrite_d, pendRank_d, pendChop_d, pendClose_d};
			pendBank_q <= pendBank_d;
			pendRow_q <= pendRow_d;
			pendCol_q <= pendCol_d;
			refPend_q <= refPend_d;
			refTimer_q <= refTimer_d;
			lat_q <= lat_d;
			cke_q <= cke_d;
			csN_q <= csN_d;
			term_q <= term_d;
			cmd_q <= cmd_d;
			ba_q <= ba_d;
			addr_q <= addr_d;
			{rstN_q, ckEn_q, ready_q, done_q, pdAct_q, srAct_q, init_q} <=
				{rstN_d, ckEn_d, ready_d, done_d, pdAct_d, srAct_d, init_d};
		end
	end

	assign {reqReady, reqDone, pdActive, srActive, initDone} = {ready_q, done_q, pdAct_q, srAct_q, init_q};
	assign {memResetN, ckEnable, cke, csN, termEnable} = {rstN_q, ckEn_q, cke_q, csN_q, term_q};
	assign {rasN, casN, weN} = cmd_q;
	assign {ba, addr, readLatency} = {ba_q, addr_q, lat_q};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic isAct, isAcc;
	assign isAct = (state_q == drs_pkg::S_IDLE) && (cmd_d == `DRS_CMD_ACT);
	assign isAcc = (state_q == drs_pkg::S_IDLE) && pendClr;
	sequence sRowMiss;
		(state_q == drs_pkg::S_IDLE) && (trkOp[pendRank_q] == drs_pkg::TRK_PRE) && !pendClr;
	endsequence
	// a refresh of both ranks may slip in between the precharge and the activate
	sequence sReopen;
		##[1:48] isAct;
	endsequence

	act_row_a: assert property (isAct |=> addr_q == $past(pendRow_q) && cmd_q == `DRS_CMD_ACT)
		else $error("activate without row address");
	col_addr_a: assert property (isAcc |=> addr_q[9:0] == $past(pendCol_q))
		else $error("column address wrong");
	auto_close_a: assert property (isAcc |=> addr_q[10] == $past(pendClose_q))
		else $error("auto close flag wrong");
	pre_all_a: assert property (trkOp[0] == drs_pkg::TRK_PREALL |=> addr_q[10] && cmd_q == `DRS_CMD_PRE)
		else $error("precharge all without bit 10");
	bank_sel_a: assert property ((isAct || isAcc) |=> ba_q == $past(pendBank_q))
		else $error("bank select wrong");
	mode_load_a: assert property (cmd_q == `DRS_CMD_LMR && csN_q != 2'h3 |-> ba_q == `DRS_MR0_SEL && addr_q == modeOp)
		else $error("mode load op-code wrong");
	chop_sel_a: assert property (isAcc |=> addr_q[12] == !$past(pendChop_q))
		else $error("chop select inverted");
	pd_cke_a: assert property (state_q == drs_pkg::S_PD |-> cke_q == 2'h0)
		else $error("clock enable high in power-down");
	one_rank_a: assert property ($onehot0(~csN_q))
		else $error("both ranks selected");
	ref_served_a: assert property (refPend_q[0] && state_q == drs_pkg::S_IDLE |-> ##[1:40] !refPend_q[0])
		else $error("refresh not served");
	hot_rate_a: assert property (refTimer_q == 9'h000 && init_q |=>
		refTimer_q == ($past(hotTemp) ? `DRS_REFI_HOT_CYC - 1 : `DRS_REFI_NORM_CYC - 1))
		else $error("refresh interval wrong");
	latency_a: assert property ($rose(rstN_q) |-> lat_q == (($past(speedGrade) == 2'h0) ? `DRS_RL_GRADE0 :
		($past(speedGrade) == 2'h1) ? `DRS_RL_GRADE1 :
		($past(speedGrade) == 2'h2) ? `DRS_RL_GRADE2 : `DRS_RL_GRADE3))
		else $error("read latency mismatch");
	idle_nop_a: assert property (csN_q == 2'h3 |-> cmd_q == `DRS_CMD_NOP)
		else $error("strobes active while deselected");
	miss_reopen_a: assert property (sRowMiss |-> sReopen)
		else $error("row miss not reopened");
	ck_first_a: assert property ($rose(cke_q[0]) |-> ckEn_q && $past(ckEn_q, 2))
		else $error("clock enable rose with clock stopped");
endmodule

// [drs_mem_model.sv]
// behavioural model of the two-rank memory seen at the controller pins
`include "drs_map.svh"
module drs_mem_model (
	// clock
	input wire logic sys_clk,
	// memory pins
	input wire logic memResetN,
	input wire logic ckEnable,
	input wire logic [1:0] cke,
	input wire logic [1:0] csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [2:0] ba,
	input wire logic [14:0] addr,
	// observation
	output int errCount,
	output logic [3:0] modeLat,
	output logic [14:0] hitRow,
	output int refGap
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] openRow [2][8];
	logic [7:0] isOpen [2];
	logic [1:0] inSr;
	logic ckRan;
	logic [2:0] cmd;
	int sinceCmd;
	int sinceRef;
	assign cmd = {rasN, casN, weN};
	initial errCount = 0;
	always @(posedge sys_clk or negedge memResetN) begin
		if (!memResetN) begin
			isOpen[0] <= 8'h00;
			isOpen[1] <= 8'h00;
			inSr <= 2'b00;
			ckRan <= 1'b0;
			sinceCmd <= 99;
			sinceRef <= 0;
			refGap <= 0;
		end else begin
			sinceCmd <= sinceCmd + 1;
			sinceRef <= sinceRef + 1;
			ckRan <= ckEnable;
			// each rank keeps its own state
			for (int r = 0; r < 2; r++) begin
				// exit on clock-enable rise, clock must already run
				if (inSr[r] && cke[r]) begin
					inSr[r] <= 1'b0;
					if (!ckRan) errCount++;
				end
				// decode only on running clock, select low
				if (ckEnable && !csN[r] && !inSr[r] && (cke[r] || cmd == `DRS_CMD_REF)) begin
					if (sinceCmd < `DRS_CMD_GAP_CYC || csN === 2'b00) errCount++;
					sinceCmd <= 0;
					case (cmd)
						`DRS_CMD_LMR: begin
							// bank inputs pick the mode register
							if (ba == `DRS_MR0_SEL && r == 0) modeLat <= addr[`DRS_MR0_LAT_LSB +: 4];
						end
						`DRS_CMD_ACT: begin
							// row opened in the named bank
							if (isOpen[r][ba]) errCount++;
							isOpen[r][ba] <= 1'b1;
							openRow[r][ba] <= addr;
						end
						`DRS_CMD_RD, `DRS_CMD_WR: begin
							// access needs an open row, bit 10 closes it
							if (!isOpen[r][ba]) errCount++;
							// read strobes follow the clock pair, so it must have run
							if (!ckRan) errCount++;
							hitRow <= openRow[r][ba];
							if (addr[`DRS_AUTO_CLOSE_BIT]) isOpen[r][ba] <= 1'b0;
						end
						`DRS_CMD_PRE: begin
							// bit 10 selects one bank or all
							if (addr[`DRS_AUTO_CLOSE_BIT]) isOpen[r] <= 8'h00;
							else isOpen[r][ba] <= 1'b0;
						end
						`DRS_CMD_REF: begin
							// refresh only with all banks idle; low clock-enable enters self refresh
							if (isOpen[r] != 8'h00) errCount++;
							if (!cke[r]) inSr[r] <= 1'b1;
							if (r == 0 && cke[r]) begin
								refGap <= sinceRef;
								sinceRef <= 0;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end
endmodule

// [test_drs_host_ctrl.sv]
// self-checking bench of the host controller against the memory model
`include "drs_map.svh"
module test_drs_host_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0;
	logic sys_rst = 1;
	logic [1:0] speedGrade = 0;
	logic hotTemp = 0;
	logic reqValid = 0, reqWrite = 0, reqRank = 0, reqChopFour = 0, reqAutoClose = 0, pdReq = 0, srReq = 0;
	logic [2:0] reqBank = 0;
	logic [14:0] reqRow = 0;
	logic [9:0] reqCol = 0;
	logic reqReady, reqDone, pdActive, srActive, initDone, memResetN, ckEnable, rasN, casN, weN;
	logic [3:0] readLatency, modeLat;
	logic [1:0] cke, csN, termEnable;
	logic [2:0] ba;
	logic [14:0] addr, hitRow;
	logic [31:0] rv;
	int errCount, refGap;
	int n_mismatch = 0;
	int checked = 0;
	always #12.5 sys_clk = ~sys_clk;
	drs_host_ctrl #(.RstHoldCyc(4), .CkeWaitCyc(4)) i_drs_host_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.speedGrade(speedGrade), .hotTemp(hotTemp), .reqValid(reqValid), .reqWrite(reqWrite), .reqRank(reqRank),
		.reqBank(reqBank), .reqRow(reqRow), .reqCol(reqCol), .reqChopFour(reqChopFour),
		.reqAutoClose(reqAutoClose), .reqReady(reqReady), .reqDone(reqDone), .pdReq(pdReq), .srReq(srReq),
		.pdActive(pdActive), .srActive(srActive), .initDone(initDone), .readLatency(readLatency),
		.memResetN(memResetN), .ckEnable(ckEnable), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
		.ba(ba), .addr(addr), .termEnable(termEnable));
	drs_mem_model i_drs_mem_model (.sys_clk(sys_clk), .memResetN(memResetN), .ckEnable(ckEnable), .cke(cke),
		.csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr), .errCount(errCount),
		.modeLat(modeLat), .hitRow(hitRow), .refGap(refGap));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	function automatic logic [3:0] expLat(input logic [1:0] g);
		case (g)
			2'd0: return `DRS_RL_GRADE0;
			2'd1: return `DRS_RL_GRADE1;
			2'd2: return `DRS_RL_GRADE2;
			default: return `DRS_RL_GRADE3;
		endcase
	endfunction
	task automatic access(input logic w, input logic r, input logic [2:0] b, input logic [14:0] row,
		input logic [9:0] col, input logic ch, input logic ac);
		int i;
		reqWrite = w;
		reqRank = r;
		reqBank = b;
		reqRow = row;
		reqCol = col;
		reqChopFour = ch;
		reqAutoClose = ac;
		reqValid = 1;
		for (i = 0; i < 300 && reqReady !== 1'b1; i++) tick(1);
		tick(1);
		reqValid = 0;
		for (i = 0; i < 300 && reqDone !== 1'b1; i++) tick(1);
		check(reqDone === 1'b1 && {rasN, casN, weN} === (w ? `DRS_CMD_WR : `DRS_CMD_RD), "access code");
		check(csN[r] === 1'b0 && csN[!r] === 1'b1 && termEnable === (w ? 2'(1 << r) : 2'b00), "rank");
		check(ba === b && addr[9:0] === col, "bank or column");
		check(addr[`DRS_AUTO_CLOSE_BIT] === ac, "auto close bit");
		check(addr[`DRS_CHOP_BIT] === !ch, "chop select bit");
		tick(1);
		check(hitRow === row, "open row");
	endtask
	initial begin
		#500000;
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		rv = $urandom(15556);
		for (int g = 0; g < 4; g++) begin
			speedGrade = 2'(g);
			sys_rst = 1;
			tick(10);
			sys_rst = 0;
			for (int i = 0; i < 300 && initDone !== 1'b1; i++) tick(1);
			check(readLatency === expLat(2'(g)) && modeLat === expLat(2'(g)), "latency");
			check(memResetN === 1'b1 && cke === 2'b11 && reqReady === 1'b1, "init pins");
		end
		$display("test init done");
		// row miss, other rank, reuse after auto close
		access(0, 0, 3'h0, 15'h0000, 10'h000, 0, 0);
		access(1, 0, 3'h0, 15'h7fff, 10'h3ff, 1, 0);
		access(1, 1, 3'h0, 15'h1234, 10'h155, 0, 1);
		access(0, 1, 3'h0, 15'h4321, 10'h2aa, 1, 0);
		repeat (40) begin
			rv = $urandom;
			access(rv[0], rv[1], rv[4:2], rv[21] ? rv[31:17] : {13'h0000, rv[8:7]}, rv[18:9], rv[19], rv[20]);
		end
		$display("test access done");
		// start right after a rank 1 refresh so no refresh cuts the power tests short
		for (int i = 0; i < 400 && !(csN === 2'b01 && {rasN, casN, weN} === `DRS_CMD_REF); i++) tick(1);
		access(0, 0, 3'h5, 15'h0001, 10'h001, 0, 0);
		pdReq = 1;
		tick(3);
		check(cke === 2'b00 && pdActive === 1'b1, "active power-down");
		pdReq = 0;
		tick(4);
		check(cke === 2'b11 && pdActive === 1'b0, "power-down exit");
		$display("test power-down done");
		srReq = 1;
		for (int i = 0; i < 200 && srActive !== 1'b1; i++) tick(1);
		// gap of two cycles, then the clock stops one cycle later
		tick(3);
		check(srActive === 1'b1 && ckEnable === 1'b0 && cke === 2'b00, "self refresh");
		srReq = 0;
		// ready stays high through self refresh, so wait on the clock enables instead
		for (int i = 0; i < 200 && cke !== 2'b11; i++) tick(1);
		check(srActive === 1'b0 && cke === 2'b11 && ckEnable === 1'b1, "self refresh exit");
		access(1, 1, 3'h5, 15'h0002, 10'h003, 0, 1);
		$display("test self refresh done");
		tick(700);
		check(refGap >= `DRS_REFI_NORM_CYC - 3 && refGap <= `DRS_REFI_NORM_CYC + 3, "normal refresh");
		hotTemp = 1;
		tick(600);
		check(refGap >= `DRS_REFI_HOT_CYC - 3 && refGap <= `DRS_REFI_HOT_CYC + 3, "hot refresh");
		check(errCount == 0, "memory model");
		$display("test refresh done");
		report_and_stop;
	end
endmodule
